// File: src/trunk_group_port_selector.sv
// Purpose: Trunk grouping, egress member choice and LACP key checks
// Assumes: APB slave, 50 MHz clock, link state sampled from pins
// Notes: Frame descriptors pass a two-entry buffer before selection
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// R1 - Aggregate only the four external ports; two static or two dynamic groups
// R2 - Any subset of external ports may form a group
// R3 - Members need same VLAN, speed and full duplex to aggregate (code checks speed and VLAN; half-duplex ports get no traffic)
// R4 - Lowest-numbered member's settings apply to the whole group
// R5 - Failed member links are dropped; traffic uses remaining links
// R6 - Egress member chosen by hashing fields of configured method
// R7 - Non-IP selector: source MAC, destination MAC, or both
// R8 - IP selector: three MAC and three IP choices, set separately
// R9 - Per-port membership flag for each static group
// R10 - Each static group has an on/off control
// R11 - Global enable turns dynamic negotiation on or off
// R12 - Configurable system priority value is held
// R13 - Per-port priority, default 128; lower value wins precedence (the value is only stored and read back)
// R14 - Dynamic aggregation only between ports with equal admin keys
// R15 - Per-port mode enable lets a port join a dynamic group
// R16 - Operational key and aggregation status readable per port
// R17 - Spanning tree sees a group as one link; redundant group blocked
// R18 - Member index is hash modulo count of active members
// R19 - Port in at most one group; groups hold two to four ports
module trunk_group_port_selector
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Link pins: up, speed (1 = 1000), full duplex
    input wire logic [3:0] i_link_up,
    input wire logic [3:0] i_link_fast,
    input wire logic [3:0] i_link_fdx,
    // Frame descriptor in
    input wire logic i_frm_valid,
    input wire trunk_pkg::frame_desc_t i_frm_desc,
    output logic o_frm_ready,
    // Egress decision out
    output logic o_egr_valid,
    output logic [3:0] o_egr_port_mask,
    input wire logic i_egr_ready,
    // Group view for spanning tree and port config
    output logic [3:0] o_stp_block,
    output logic [3:0] o_cfg_master
);
    localparam int NP = trunk_pkg::NUM_PORTS;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    typedef struct packed
    {
        logic [2:0] nonip_dist;
        logic [2:0] ip_dist;
        logic [1:0][3:0] st_member;
        logic [1:0] st_enable;
        logic lacp_en;
        logic [15:0] sys_prio;
        logic [3:0][7:0] port_prio;
        logic [3:0][3:0] admin_key;
        logic [3:0][3:0] port_vlan;
        logic [3:0] dyn_mode;
        logic [2:0][11:0] link_sync;
        logic [11:0] link;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic egr_valid;
        logic [3:0] egr_mask;
        logic [3:0] stp_block;
        logic [3:0] cfg_master;
    } state_t;
    state_t st;
    state_t next_st;
    trunk_stream_if buf_in();
    trunk_stream_if buf_out();
    logic [1:0][3:0] grp_mask;
    logic [3:0] grp_valid;
    logic [3:0] port_ok;
    logic [31:0] hash;
    logic [3:0] active;
    logic [2:0] n_active;
    logic [1:0] pick;
    logic wr_en;
    logic rd_en;
    logic egr_free;
    // ==========================================================
    // Functions
    function automatic logic [31:0] fold48(input logic [47:0] v);
        fold48 = v[31:0] ^ {16'h0000, v[47:32]};
    endfunction
    function automatic logic [2:0] popcnt4(input logic [3:0] m);
        popcnt4 = 3'({2'h0, m[0]} + {2'h0, m[1]} + {2'h0, m[2]} + {2'h0, m[3]});
    endfunction
    function automatic logic [3:0] lowest(input logic [3:0] m);
        lowest = m & (~m + 4'h1);
    endfunction
    function automatic logic [1:0] first_idx(input logic [3:0] m);
        first_idx = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
    endfunction
    function automatic logic [3:0] nth_set(input logic [3:0] a, input logic [1:0] k);
        logic [3:0] r;
        r = a;
        for (int i = 0; i < 3; i++)
        begin
            r = (2'(i) < k) ? (r & ~lowest(r)) : r;
        end
        nth_set = lowest(r);
    endfunction
    // ==========================================================
    // Input buffer
    assign buf_in.valid = i_frm_valid;
    assign buf_in.data = i_frm_desc;
    assign o_frm_ready = buf_in.ready;
    trunk_skid_buffer u_buf
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .in_s(buf_in.snk),
        .out_s(buf_out.src)
    );
    // ==========================================================
    // Group formation
    always_comb
    begin
        logic [1:0] mi;
        mi = 2'h0;
        for (int p = 0; p < NP; p++)
        begin
            port_ok[p] = st.link[p] && st.link[8 + p]; // R3
        end
        grp_mask = '0;
        // Static groups: enabled and no overlap with group 0
        for (int g = 0; g < 2; g++)
        begin
            if (st.st_enable[g] && !st.lacp_en) // R10
            begin
                grp_mask[g] = st.st_member[g]; // R9 R2 R1
            end
        end
        grp_mask[1] = grp_mask[1] & ~grp_mask[0]; // R19
        // Dynamic: group by admin key of lowest enabled port
        if (st.lacp_en) // R11
        begin
            for (int p = 0; p < NP; p++)
            begin
                if (st.dyn_mode[p]) // R15
                begin
                    if (grp_mask[0] == 4'h0 ||
                        st.admin_key[p] == st.admin_key[first_idx(grp_mask[0])]) // R14
                    begin
                        grp_mask[0][p] = 1'b1;
                    end
                    else if (grp_mask[1] == 4'h0 ||
                        st.admin_key[p] == st.admin_key[first_idx(grp_mask[1])])
                    begin
                        grp_mask[1][p] = 1'b1;
                    end
                end
            end
        end
        for (int g = 0; g < 2; g++)
        begin
            // Same speed and VLAN required against master
            mi = first_idx(grp_mask[g]);
            for (int p = 0; p < NP; p++)
            begin
                if (grp_mask[g][p] && (st.link[4 + p] != st.link[4 + mi] ||
                    st.port_vlan[p] != st.port_vlan[mi])) // R3
                begin
                    grp_mask[g][p] = 1'b0;
                end
            end
            if (popcnt4(grp_mask[g]) < 3'h2) // R19
            begin
                grp_mask[g] = 4'h0;
            end
        end
        grp_valid = {2'h0, grp_mask[1] != 4'h0, grp_mask[0] != 4'h0};
    end
    // ==========================================================
    // Hash and member choice
    always_comb
    begin
        trunk_pkg::frame_desc_t d;
        d = buf_out.data;
        case (d.is_ip ? st.ip_dist : st.nonip_dist) // R6 R7 R8
            3'h0: hash = fold48(d.src_mac);
            3'h1: hash = fold48(d.dst_mac);
            3'h2: hash = fold48(d.src_mac) ^ fold48(d.dst_mac);
            3'h3: hash = d.src_ip;
            3'h4: hash = d.dst_ip;
            3'h5: hash = d.src_ip ^ d.dst_ip;
            default: hash = fold48(d.src_mac);
        endcase
        active = (d.group[1] ? 4'h0 : grp_mask[d.group[0]]) & port_ok; // R5
        n_active = popcnt4(active);
        pick = (n_active == 3'h0) ? 2'h0 : 2'(hash[7:0] % {5'h00, n_active}); // R18
    end
    assign egr_free = !st.egr_valid || i_egr_ready;
    assign buf_out.ready = egr_free;
    assign wr_en = i_psel && i_penable && i_pwrite && st.pready;
    assign rd_en = i_psel && i_penable && !i_pwrite && !st.pready;
    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.link_sync[0] = {i_link_fdx, i_link_fast, i_link_up};
        next_st.link_sync[1] = st.link_sync[0];
        next_st.link_sync[2] = st.link_sync[1];
        if (st.link_sync[1] == st.link_sync[2])
        begin
            next_st.link = st.link_sync[2];
        end
        // Egress output
        if (egr_free)
        begin
            next_st.egr_valid = buf_out.valid;
            next_st.egr_mask = (buf_out.data.group[1] || active == 4'h0) ?
                4'h0 : nth_set(active, pick); // R5
        end
        // Master and spanning tree view
        next_st.cfg_master = lowest(grp_mask[0]) | lowest(grp_mask[1]); // R4 R17
        next_st.stp_block = (grp_valid[0] && grp_valid[1]) ? grp_mask[1] : 4'h0; // R17
        // APB
        next_st.pready = i_psel && i_penable && !st.pready;
        next_st.pslverr = i_psel && i_penable && i_pwrite && !st.pready &&
            (i_paddr > trunk_pkg::REG_GROUPS);
        if (wr_en)
        begin
            case (i_paddr)
                trunk_pkg::REG_DIST:
                begin
                    if (i_pwdata[2:0] < 3'(trunk_pkg::NONIP_METHODS))
                    begin
                        next_st.nonip_dist = i_pwdata[2:0]; // R7
                    end
                    if (i_pwdata[6:4] < trunk_pkg::IP_METHODS)
                    begin
                        next_st.ip_dist = i_pwdata[6:4]; // R8
                    end
                end
                trunk_pkg::REG_STATIC0, trunk_pkg::REG_STATIC1:
                begin
                    next_st.st_member[i_paddr[3]] = i_pwdata[3:0]; // R9
                    next_st.st_enable[i_paddr[3]] = i_pwdata[trunk_pkg::STATIC_EN_BIT]; // R10
                end
                trunk_pkg::REG_LACP:
                begin
                    next_st.sys_prio = i_pwdata[15:0]; // R12
                    next_st.lacp_en = i_pwdata[trunk_pkg::LACP_EN_BIT]; // R11
                end
                8'h10, 8'h14, 8'h18, trunk_pkg::REG_PORT3:
                begin
                    next_st.port_prio[i_paddr[3:2]] = i_pwdata[7:0]; // R13
                    next_st.admin_key[i_paddr[3:2]] = i_pwdata[11:8];
                    next_st.port_vlan[i_paddr[3:2]] = i_pwdata[15:12];
                    next_st.dyn_mode[i_paddr[3:2]] = i_pwdata[trunk_pkg::PORT_MODE_BIT]; // R15
                end
                default: next_st.pslverr = 1'b0;
            endcase
        end
        if (rd_en)
        begin
            next_st.prdata = 32'h00000000;
            case (i_paddr)
                trunk_pkg::REG_DIST: next_st.prdata = {25'h0, st.ip_dist, 1'b0, st.nonip_dist};
                trunk_pkg::REG_STATIC0: next_st.prdata = {27'h0, st.st_enable[0], st.st_member[0]};
                trunk_pkg::REG_STATIC1: next_st.prdata = {27'h0, st.st_enable[1], st.st_member[1]};
                trunk_pkg::REG_LACP: next_st.prdata = {15'h0, st.lacp_en, st.sys_prio};
                trunk_pkg::REG_LINK: next_st.prdata = {20'h0, st.link};
                trunk_pkg::REG_GROUPS: next_st.prdata = {24'h0, grp_mask[1], grp_mask[0]};
                default:
                begin
                    if (i_paddr >= trunk_pkg::REG_PORT0 && i_paddr <= trunk_pkg::REG_PORT3)
                    begin
                        next_st.prdata = {7'h0, st.dyn_mode[i_paddr[3:2]], 8'h0,
                            st.port_vlan[i_paddr[3:2]], st.admin_key[i_paddr[3:2]],
                            st.port_prio[i_paddr[3:2]]};
                    end
                    else if (i_paddr >= trunk_pkg::REG_STATUS0 &&
                        i_paddr <= trunk_pkg::REG_STATUS3)
                    begin
                        // Operational key and status
                        next_st.prdata = {26'h0,
                            (grp_mask[0][2'(i_paddr[5:2] - 4'h9)] ||
                             grp_mask[1][2'(i_paddr[5:2] - 4'h9)]) ?
                            (st.lacp_en ? 2'(trunk_pkg::AGG_DYNAMIC) :
                                2'(trunk_pkg::AGG_STATIC)) :
                            2'(trunk_pkg::AGG_INDIVIDUAL),
                            st.admin_key[2'(i_paddr[5:2] - 4'h9)]}; // R16
                    end
                    else
                    begin
                        next_st.pslverr = 1'b1;
                    end
                end
            endcase
        end
    end
    // ==========================================================
    // State register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.sys_prio <= trunk_pkg::SYS_PRIO_RST;
            st.port_prio <= {4{trunk_pkg::PORT_PRIO_RST}}; // R13
            st.admin_key <= {4{trunk_pkg::ADMIN_KEY_RST}};
        end
        else
        begin
            st <= next_st;
        end
    end
    assign o_prdata = st.prdata;
    assign o_pready = st.pready;
    assign o_pslverr = st.pslverr;
    assign o_egr_valid = st.egr_valid;
    assign o_egr_port_mask = st.egr_mask;
    assign o_stp_block = st.stp_block;
    assign o_cfg_master = st.cfg_master;
    // ==========================================================
    // Checks
    property p_egr_one_hot;
        o_egr_valid |-> $onehot0(o_egr_port_mask);
    endproperty
    a_egr_one_hot: assert property (p_egr_one_hot) else $error("egress mask not one hot"); // R6
    property p_egr_live;
        (egr_free && buf_out.valid) |=> ((o_egr_port_mask & ~$past(port_ok)) == 4'h0);
    endproperty
    a_egr_live: assert property (p_egr_live) else $error("egress to failed link"); // R5
    property p_grp_disjoint;
        (grp_mask[0] & grp_mask[1]) == 4'h0;
    endproperty
    a_grp_disjoint: assert property (p_grp_disjoint) else $error("port in two groups"); // R19
    property p_grp_size;
        popcnt4(grp_mask[0]) != 3'h1 && popcnt4(grp_mask[1]) != 3'h1;
    endproperty
    a_grp_size: assert property (p_grp_size) else $error("group of one port"); // R19
    property p_static_off;
        (!st.lacp_en && !st.st_enable[0]) |-> grp_mask[0] == 4'h0;
    endproperty
    a_static_off: assert property (p_static_off) else $error("disabled group active"); // R10
    property p_dyn_mode;
        st.lacp_en |-> (((grp_mask[0] | grp_mask[1]) & ~st.dyn_mode) == 4'h0);
    endproperty
    a_dyn_mode: assert property (p_dyn_mode) else $error("port joined without mode"); // R15
    property p_stp;
        (grp_valid[0] && grp_valid[1]) |=> o_stp_block == $past(grp_mask[1]);
    endproperty
    a_stp: assert property (p_stp) else $error("redundant group not blocked"); // R17
    sequence s_apb_access;
        i_psel && i_penable && !o_pready;
    endsequence
    property p_apb_ready;
        s_apb_access |=> o_pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb access not answered");
endmodule

// File: src/trunk_pkg.sv
// Purpose: Shared constants and types for the trunk group port selector
// Assumes: Four external ports, two static and two dynamic groups
// Notes: Register byte offsets are word aligned on a 32-bit APB bus
package trunk_pkg;
    localparam int NUM_PORTS = 4;
    localparam int NUM_GROUPS = 2;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] REG_DIST = 8'h00;
    localparam logic [7:0] REG_STATIC0 = 8'h04;
    localparam logic [7:0] REG_STATIC1 = 8'h08;
    localparam logic [7:0] REG_LACP = 8'h0c;
    localparam logic [7:0] REG_PORT0 = 8'h10;
    localparam logic [7:0] REG_PORT3 = 8'h1c;
    localparam logic [7:0] REG_LINK = 8'h20;
    localparam logic [7:0] REG_STATUS0 = 8'h24;
    localparam logic [7:0] REG_STATUS3 = 8'h30;
    localparam logic [7:0] REG_GROUPS = 8'h34;
    // ==========================================================
    // Field positions
    localparam int DIST_NONIP_LSB = 0;
    localparam int DIST_IP_LSB = 4;
    localparam int STATIC_EN_BIT = 4;
    localparam int LACP_EN_BIT = 16;
    localparam int PORT_KEY_LSB = 8;
    localparam int PORT_MODE_BIT = 24;
    localparam int PORT_VLAN_LSB = 12;
    localparam int LINK_SPEED_LSB = 4;
    localparam int LINK_FDX_LSB = 8;
    // ==========================================================
    // Reset values and method counts
    localparam logic [15:0] SYS_PRIO_RST = 16'h8000;
    localparam logic [7:0] PORT_PRIO_RST = 8'h80;
    localparam logic [3:0] ADMIN_KEY_RST = 4'h1;
    localparam logic [2:0] IP_METHODS = 3'h6;
    localparam logic [1:0] NONIP_METHODS = 2'h3;
    // ==========================================================
    // Distribution methods
    typedef enum logic [2:0]
    {
        DIST_SRC_MAC,
        DIST_DST_MAC,
        DIST_BOTH_MAC,
        DIST_SRC_IP,
        DIST_DST_IP,
        DIST_BOTH_IP
    } dist_t;
    // Aggregation status per port
    typedef enum logic [1:0]
    {
        AGG_INDIVIDUAL,
        AGG_STATIC,
        AGG_DYNAMIC
    } agg_status_t;
    typedef struct packed
    {
        logic [47:0] src_mac;
        logic [47:0] dst_mac;
        logic [31:0] src_ip;
        logic [31:0] dst_ip;
        logic is_ip;
        logic [1:0] group;
    } frame_desc_t;
    localparam int DESC_W = $bits(frame_desc_t);
endpackage

// File: src/trunk_skid_buffer.sv
// Purpose: Two-entry buffer in the descriptor path
// Assumes: Source holds data while valid and not ready
// Notes: Read data come out of registers
`timescale 1ns/1ps
module trunk_skid_buffer
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Streams
    trunk_stream_if.snk in_s,
    trunk_stream_if.src out_s
);
    typedef struct packed
    {
        trunk_pkg::frame_desc_t [1:0] mem;
        logic [1:0] count;
        logic rd;
        logic rdy;
    } buf_state_t;
    buf_state_t st;
    buf_state_t next_st;
    logic push;
    logic pop;
    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        push = in_s.valid && st.rdy;
        pop = out_s.ready && (st.count != 2'h0);
        if (push)
        begin
            next_st.mem[st.rd ^ st.count[0]] = in_s.data;
        end
        if (pop)
        begin
            next_st.rd = ~st.rd;
        end
        next_st.count = 2'(st.count + {1'b0, push} - {1'b0, pop});
        next_st.rdy = (next_st.count != 2'h2);
    end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign in_s.ready = st.rdy;
    assign out_s.valid = (st.count != 2'h0);
    assign out_s.data = st.mem[st.rd];
endmodule

// File: src/trunk_stream_if.sv
// Purpose: Valid/ready carrier between the selector and its skid buffer
// Assumes: Single clock domain
// Notes: Data is one frame descriptor
`timescale 1ns/1ps
interface trunk_stream_if;
    logic valid;
    logic ready;
    trunk_pkg::frame_desc_t data;
    modport src
    (
        output valid,
        output data,
        input ready
    );
    modport snk
    (
        input valid,
        input data,
        output ready
    );
endinterface

// File: tb/link_partner_model.sv
// Purpose: Link partner switch at the four external ports
// Assumes: Partner ports run at 1000 and full duplex
// Notes: Egress ready can stall, or alternate to act as a slow receiver
`timescale 1ns/1ps
module link_partner_model
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Controls
    input wire logic i_stall,
    input wire logic i_slow,
    input wire logic [3:0] i_down,
    // Pins
    output logic [3:0] o_link_up,
    output logic [3:0] o_link_fast,
    output logic [3:0] o_link_fdx,
    output logic o_egr_ready
);
    logic tgl;
    assign o_link_fast = 4'hf;
    assign o_link_fdx = 4'hf;
    assign o_link_up = ~i_down;
    assign o_egr_ready = ~i_stall & (~i_slow | tgl);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            tgl <= 1'b0;
        else
            tgl <= ~tgl;
    end
endmodule

// File: tb/tb_trunk_group_port_selector.sv
// Purpose: Self-checking bench for the trunk group port selector
// Assumes: APB slave answers without a fixed wait count
// Notes: Members are ordered by port number for the hash index
`timescale 1ns/1ps
module tb_trunk_group_port_selector;
    logic i_clk = 1'b0, i_rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, fv = 1'b0;
    logic stall = 1'b0, slow = 1'b0, err, rdy, slv, frdy, ev, er;
    logic [7:0] pa = 8'h0;
    logic [31:0] pwd = 32'h0, rd, prd;
    logic [3:0] down = 4'h0, up, fast, fdx, em, blk, mst;
    logic [2:0] k, o;
    trunk_pkg::frame_desc_t fd = '0;
    logic [3:0] q[$];
    int failures = 0, tests_run = 0, n;
    int fs[6] = '{0, 1, 0, 2, 3, 2};
    trunk_group_port_selector u_trunk_group_port_selector (.i_clk(i_clk), .i_rst(i_rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(rdy), .o_pslverr(slv), .i_link_up(up), .i_link_fast(fast),
        .i_link_fdx(fdx), .i_frm_valid(fv), .i_frm_desc(fd), .o_frm_ready(frdy),
        .o_egr_valid(ev), .o_egr_port_mask(em), .i_egr_ready(er), .o_stp_block(blk),
        .o_cfg_master(mst));
    link_partner_model u_link_partner_model (.i_clk(i_clk), .i_rst(i_rst), .i_stall(stall),
        .i_slow(slow), .i_down(down), .o_link_up(up), .o_link_fast(fast), .o_link_fdx(fdx),
        .o_egr_ready(er));
    initial
    begin
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        if (ev === 1'b1 && er === 1'b1)
            q.push_back(em);
    end
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do @(posedge i_clk); while (rdy !== 1'b1);
        rd = prd;
        err = slv;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic frm(input int s, input logic [7:0] v, input logic ip, input logic [1:0] g,
        input logic [3:0] e);
        trunk_pkg::frame_desc_t d;
        d = '0;
        case (s)
            0: d.src_mac[7:0] = v;
            1: d.dst_mac[7:0] = v;
            2: d.src_ip[7:0] = v;
            default: d.dst_ip[7:0] = v;
        endcase
        d.is_ip = ip;
        d.group = g;
        @(posedge i_clk);
        fd <= d;
        fv <= 1'b1;
        do @(posedge i_clk); while (frdy !== 1'b1);
        fv <= 1'b0;
        n = 0;
        while (q.size() == 0 && n < 40)
        begin
            @(posedge i_clk);
            n++;
        end
        n = q.size();
        chk({27'h0, n == 0, (n == 0) ? 4'h0 : q.pop_front()}, {28'h0, e});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rdc(trunk_pkg::REG_LACP, {16'h0, trunk_pkg::SYS_PRIO_RST});
        rdc(trunk_pkg::REG_PORT0, {20'h0, trunk_pkg::ADMIN_KEY_RST, 8'h80});
        apb(1'b0, 8'h3c, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1'b1, trunk_pkg::REG_STATIC0, 32'h1a);
        slow <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk({28'h0, mst}, 32'h2);
        for (int c = 0; c < 9; c++)
        begin
            k = 3'(c > 2 ? c - 3 : c);
            o = (k == 3'h0) ? 3'h1 : 3'h0;
            apb(1'b1, 8'h0, (c > 2) ? {25'h0, k, 1'b0, o} : {25'h0, o, 1'b0, k});
            frm(fs[k], 8'h01, c > 2, 2'h0, 4'h8);
            frm(fs[k], 8'h02, c > 2, 2'h0, 4'h2);
        end
        $display("test distribution done");
        down <= 4'b0010;
        repeat (8) @(posedge i_clk);
        frm(0, 8'h02, 1'b0, 2'h0, 4'h8);
        down <= 4'b1010;
        repeat (8) @(posedge i_clk);
        frm(0, 8'h01, 1'b0, 2'h0, 4'h0);
        down <= 4'h0;
        apb(1'b1, trunk_pkg::REG_STATIC0, 32'h0a);
        repeat (8) @(posedge i_clk);
        frm(0, 8'h01, 1'b0, 2'h0, 4'h0);
        $display("test failover done");
        apb(1'b1, trunk_pkg::REG_STATIC0, 32'h1a);
        apb(1'b1, trunk_pkg::REG_STATIC1, 32'h15);
        repeat (8) @(posedge i_clk);
        chk({28'h0, blk}, 32'h5);
        chk({28'h0, mst}, 32'h3);
        frm(0, 8'h01, 1'b0, 2'h1, 4'h4);
        $display("test two groups done");
        stall <= 1'b1;
        fd <= '0;
        fv <= 1'b1;
        n = 0;
        repeat (10)
        begin
            @(posedge i_clk);
            if (frdy === 1'b1)
                n++;
        end
        fv <= 1'b0;
        chk({31'h0, frdy}, 32'h0);
        stall <= 1'b0;
        repeat (30) @(posedge i_clk);
        chk(q.size(), n);
        q.delete();
        $display("test buffer done");
        apb(1'b1, trunk_pkg::REG_LACP, 32'h0001_8000);
        apb(1'b1, trunk_pkg::REG_PORT0, 32'h0100_0180);
        apb(1'b1, 8'h14, 32'h0100_0180);
        apb(1'b1, 8'h18, 32'h0100_0580);
        repeat (8) @(posedge i_clk);
        rdc(trunk_pkg::REG_STATUS0, 32'h21);
        rdc(8'h28, 32'h21);
        rdc(8'h2c, 32'h05);
        rdc(trunk_pkg::REG_STATUS3, 32'h01);
        $display("test dynamic done");
        report_and_stop();
    end
    initial
    begin
        #400000;
        failures++;
        report_and_stop();
    end
endmodule
